// [fofm_assertions.sv]
// Checker: port relations of the frame matcher.
// Bound to fofm_matcher; sees its ports only.
`timescale 1ns/1ns
module fofm_assertions #(parameter NUM_FILT = 8) (
  // Clock, reset, bus
  input wire logic                mclk_i,
  input wire logic                rst_i,
  input wire logic                psel_i,
  input wire logic                penable_i,
  input wire logic                pready_o,
  input wire logic                pslverr_o,
  // Stream
  input wire logic                rx_eof_i,
  input wire logic [NUM_FILT-1:0] other_pass_i,
  input wire logic [NUM_FILT-1:0] verdict_o,
  input wire logic                verdict_valid_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_eof; rx_eof_i |=> verdict_valid_o; endproperty
  a_eof: assert property (p_eof) else $error("no verdict");
  property p_noeof; !rx_eof_i |=> !verdict_valid_o; endproperty
  a_noeof: assert property (p_noeof) else $error("stray verdict");
  property p_hold; !verdict_valid_o |-> $stable(verdict_o); endproperty
  a_hold: assert property (p_hold) else $error("verdict moved");
  property p_other; rx_eof_i |=> !(verdict_o & ~$past(other_pass_i)); endproperty
  a_other: assert property (p_other) else $error("blocked frame passed");
  property p_rdy; psel_i && penable_i && !pready_o |=> pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_pulse; pready_o |=> !pready_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err; pslverr_o |-> pready_o; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_idle; !(psel_i && penable_i) |=> !pready_o; endproperty
  a_idle: assert property (p_idle) else $error("ready when idle");
  c_pass: cover property (verdict_valid_o && |verdict_o);
  c_block: cover property (verdict_valid_o && !verdict_o);
  c_err: cover property (pslverr_o);
endmodule // fofm_assertions
bind fofm_matcher fofm_assertions #(.NUM_FILT(NUM_FILT)) u_chk (.mclk_i, .rst_i, .psel_i,
  .penable_i, .pready_o, .pslverr_o, .rx_eof_i, .other_pass_i, .verdict_o, .verdict_valid_o);

// [fofm_consts.vh]
// Constants for the fixed-offset frame matcher: register map, fields, resets.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef FOFM_CONSTS_VH
`define FOFM_CONSTS_VH
`define FOFM_NUM_FILT      8
`define FOFM_OFF_W         11
`define FOFM_ADDR_CTRL     12'h000
`define FOFM_ADDR_OFFSET   12'h004
`define FOFM_ADDR_FILT0    12'h040
`define FOFM_ADDR_CNT0     12'h080
`define FOFM_ADDR_MODE     12'h060
`define FOFM_FILT_STRIDE   12'h004
`define FOFM_REF_LSB       0
`define FOFM_REF_W         2
`define FOFM_REF_MAC       2'h0
`define FOFM_REF_IPV4      2'h1
`define FOFM_REF_UDP       2'h2
`define FOFM_REF_FRAME     2'h3
`define FOFM_MODE_BIT      0
`define FOFM_CODE_LSB      16
`define FOFM_MASK_LSB      0
`define FOFM_CTRL_RST      2'h0
`define FOFM_OFFSET_RST    11'h000
`define FOFM_CODE_RST      16'h0000
`define FOFM_MASK_RST      16'h0000
`endif

// [fofm_matcher.v]
// Fixed-offset frame matcher: eight filters with APB registers and frame counters.
// Assumes a receive parser on mclk_i delivering one byte per cycle with
// start-of-payload markers and an end-of-frame strobe carrying the other criteria.
//
// Function
// - A filter in ignore mode passes frames unless its other criteria block them.
// - A filter in equality mode passes a frame only if the addressed bytes match the pattern.
// - The reference point can be the start of the MAC, IPv4 or UDP payload.
// - The whole-frame reference is the first byte after the start-of-frame delimiter.
// - The reference selection is a single setting shared by all filters of the port.
// - The offset counts bytes from the reference, zero being its first byte.
// - A frame too short to hold both addressed bytes does not match.
// - The byte offset is a single setting shared by all filters of the port.
// - Each filter holds its own 16-bit comparison code.
// - The mask is ANDed with the code so only surviving bits decide the match.
// - The port provides eight independent filters with their own verdicts.
// - Each filter counts the frames that satisfy all of its selection criteria.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "fofm_consts.vh"
module fofm_matcher #(
  parameter NUM_FILT = `FOFM_NUM_FILT,
  parameter OFF_W    = `FOFM_OFF_W
) (
  // Clock and reset
  input  wire                 mclk_i,
  input  wire                 rst_i,
  // APB slave
  input  wire                 psel_i,
  input  wire                 penable_i,
  input  wire                 pwrite_i,
  input  wire [11:0]          paddr_i,
  input  wire [31:0]          pwdata_i,
  output reg  [31:0]          prdata_o,
  output reg                  pready_o,
  output reg                  pslverr_o,
  // Receive byte stream
  input  wire                 rx_valid_i,
  input  wire [7:0]           rx_data_i,
  input  wire                 rx_sof_i,
  input  wire                 rx_mac_pl_i,
  input  wire                 rx_ipv4_pl_i,
  input  wire                 rx_udp_pl_i,
  input  wire                 rx_eof_i,
  input  wire [NUM_FILT-1:0]  other_pass_i,
  // Verdicts
  output reg  [NUM_FILT-1:0]  verdict_o,
  output reg                  verdict_valid_o
);

  reg [`FOFM_REF_W-1:0] ref_sel;
  reg [OFF_W-1:0]       offset;
  reg [NUM_FILT-1:0]    mode_eq;
  reg [15:0]            code [0:NUM_FILT-1];
  reg [15:0]            mask [0:NUM_FILT-1];
  reg [31:0]            cnt  [0:NUM_FILT-1];

  reg                   armed;
  reg [OFF_W:0]         pos;
  reg [15:0]            field;
  reg [1:0]             got;

  reg                   ref_hit;
  wire                  ref_byte;
  wire                  in_frame;
  wire [OFF_W:0]        cur_pos;
  wire [OFF_W:0]        off_pos;
  wire [OFF_W:0]        off_next;
  wire                  wr;
  wire                  rd;
  wire [11:0]           filt_a;
  wire [11:0]           cnt_a;
  wire [2:0]            filt_i;
  wire [2:0]            cnt_i;
  wire                  in_filt;
  wire                  in_cnt;
  wire                  at_ctrl;
  wire                  at_offset;
  wire                  at_mode;
  reg  [1:0]            next_got;
  reg  [15:0]           next_field;
  reg  [NUM_FILT-1:0]   next_verdict;
  reg  [31:0]           next_rdata;
  reg                   next_err;
  integer               kv;
  integer               kr;
  integer               kc;

  localparam [11:0] FILT_BASE = `FOFM_ADDR_FILT0;
  localparam [11:0] CNT_BASE  = `FOFM_ADDR_CNT0;

  // Reference point selection
  always @* begin
    case (ref_sel)
      `FOFM_REF_MAC: begin
        ref_hit = rx_mac_pl_i;
      end
      `FOFM_REF_IPV4: begin
        ref_hit = rx_ipv4_pl_i;
      end
      `FOFM_REF_UDP: begin
        ref_hit = rx_udp_pl_i;
      end
      `FOFM_REF_FRAME: begin
        ref_hit = rx_sof_i;
      end
      default: begin
        ref_hit = 1'b0;
      end
    endcase
  end

  // Position counts from zero at the reference byte
  assign ref_byte = rx_valid_i & ref_hit;
  assign in_frame = rx_valid_i & (armed | ref_hit);
  assign cur_pos  = ref_byte ? {(OFF_W+1){1'b0}} : pos;
  assign off_pos  = {1'b0, offset};
  assign off_next = off_pos + {{OFF_W{1'b0}}, 1'b1};

  // Capture of the two addressed bytes
  always @* begin
    next_got   = got;
    next_field = field;
    if (in_frame & (cur_pos == off_pos)) begin
      next_got   = 2'h1;
      next_field = {field[7:0], rx_data_i};
    end else if (in_frame & (got == 2'h1) & (cur_pos == off_next)) begin
      next_got   = 2'h2;
      next_field = {field[7:0], rx_data_i};
    end
  end

  // Reference seen in the current frame
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      armed <= 1'b0;
    end else if (rx_eof_i) begin
      armed <= 1'b0;
    end else if (ref_byte) begin
      armed <= 1'b1;
    end
  end

  // Byte position from the reference, saturating
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pos <= {(OFF_W+1){1'b0}};
    end else if (rx_eof_i) begin
      pos <= {(OFF_W+1){1'b0}};
    end else if (in_frame & ~(&pos)) begin
      pos <= cur_pos + {{OFF_W{1'b0}}, 1'b1};
    end
  end

  // Addressed bytes of the current frame
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      got   <= 2'h0;
      field <= 16'h0000;
    end else if (rx_eof_i) begin
      got   <= 2'h0;
    end else if (rx_sof_i & rx_valid_i & (ref_sel != `FOFM_REF_FRAME)) begin
      got   <= 2'h0;
      field <= next_field;
    end else begin
      got   <= next_got;
      field <= next_field;
    end
  end

  // Per-filter verdict on end of frame
  always @* begin
    for (kv = 0; kv < NUM_FILT; kv = kv + 1) begin
      if (!mode_eq[kv]) begin
        next_verdict[kv] = other_pass_i[kv];
      end else begin
        next_verdict[kv] = other_pass_i[kv] & (got == 2'h2) &
                           ((field & mask[kv]) == (code[kv] & mask[kv]));
      end
    end
  end

  // APB decode
  assign wr        = psel_i & penable_i & pwrite_i & ~pready_o;
  assign rd        = psel_i & penable_i & ~pwrite_i & ~pready_o;
  assign filt_a    = paddr_i - FILT_BASE;
  assign cnt_a     = paddr_i - CNT_BASE;
  assign filt_i    = filt_a[4:2];
  assign cnt_i     = cnt_a[4:2];
  assign in_filt   = (paddr_i[11:5] == FILT_BASE[11:5]) & (paddr_i[1:0] == 2'h0);
  assign in_cnt    = (paddr_i[11:5] == CNT_BASE[11:5]) & (paddr_i[1:0] == 2'h0);
  assign at_ctrl   = (paddr_i == `FOFM_ADDR_CTRL);
  assign at_offset = (paddr_i == `FOFM_ADDR_OFFSET);
  assign at_mode   = (paddr_i == `FOFM_ADDR_MODE);

  // Read data and error for the addressed register
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (at_ctrl) begin
      next_rdata[`FOFM_REF_W-1:0] = ref_sel;
    end else if (at_offset) begin
      next_rdata[OFF_W-1:0] = offset;
    end else if (in_filt) begin
      next_rdata = {code[filt_i], mask[filt_i]};
    end else if (in_cnt) begin
      next_rdata = cnt[cnt_i];
    end else if (at_mode) begin
      next_rdata[NUM_FILT-1:0] = mode_eq;
    end else begin
      next_err = 1'b1;
    end
  end

  // Bus handshake: one wait state, answer in the second access cycle
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= (wr | rd) & next_err;
      if (rd) begin
        prdata_o <= next_rdata;
      end
    end
  end

  // Port-wide settings: reference and offset shared by all filters, one mode bit per filter
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_sel <= `FOFM_CTRL_RST;
      offset  <= `FOFM_OFFSET_RST;
      mode_eq <= {NUM_FILT{1'b0}};
    end else if (wr) begin
      if (at_ctrl) begin
        ref_sel <= pwdata_i[`FOFM_REF_W-1:0];
      end
      if (at_offset) begin
        offset <= pwdata_i[OFF_W-1:0];
      end
      if (at_mode) begin
        mode_eq <= pwdata_i[NUM_FILT-1:0];
      end
    end
  end

  // Per-filter code and mask
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (kr = 0; kr < NUM_FILT; kr = kr + 1) begin
        code[kr] <= `FOFM_CODE_RST;
        mask[kr] <= `FOFM_MASK_RST;
      end
    end else if (wr & in_filt) begin
      code[filt_i] <= pwdata_i[31:16];
      mask[filt_i] <= pwdata_i[15:0];
    end
  end

  // Verdicts, one cycle after end of frame
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      verdict_o       <= {NUM_FILT{1'b0}};
      verdict_valid_o <= 1'b0;
    end else begin
      verdict_valid_o <= rx_eof_i;
      if (rx_eof_i) begin
        verdict_o <= next_verdict;
      end
    end
  end

  // Frame counters, wrapping
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (kc = 0; kc < NUM_FILT; kc = kc + 1) begin
        cnt[kc] <= 32'h0000_0000;
      end
    end else begin
      for (kc = 0; kc < NUM_FILT; kc = kc + 1) begin
        if (rx_eof_i & next_verdict[kc]) begin
          cnt[kc] <= cnt[kc] + 32'h0000_0001;
        end
      end
    end
  end

endmodule // fofm_matcher

// [fofm_rx_model.sv]
// Receive parser model: plays the bytes in fb with payload markers.
// Caller runs on mclk_i; data line inverts in the end-of-frame cycle, when no byte is carried, then holds.
`timescale 1ns/1ns
module fofm_rx_model (
  // Clock
  input  wire logic  mclk_i,
  // Stream
  output logic       rx_valid_o = 0,
  output logic [7:0] rx_data_o = 0,
  output logic       rx_sof_o = 0,
  output logic       rx_mac_o = 0,
  output logic       rx_ipv4_o = 0,
  output logic       rx_udp_o = 0,
  output logic       rx_eof_o = 0
);
  logic [7:0] fb [0:39];
  task automatic play(input int len);
    for (int i = 0; i <= len; i++) begin
      @(posedge mclk_i);
      rx_valid_o <= i < len;
      rx_data_o <= i < len ? fb[i] : ~rx_data_o;
      {rx_sof_o, rx_mac_o, rx_ipv4_o, rx_udp_o} <= {i == 0, i == 14, i == 20, i == 28};
      rx_eof_o <= i == len;
    end
    @(posedge mclk_i);
    rx_eof_o <= 0;
  endtask
endmodule // fofm_rx_model

// [fofm_tb.sv]
// Bench for the frame matcher: registers, frames against all references, counters.
// Assumes the matcher, its checker and the receive model.
`timescale 1ns/1ns
`include "fofm_consts.vh"
module testbench;
  logic        mclk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, e;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd, cnt[8] = '{default: 0};
  logic        pready_o, pslverr_o, verdict_valid_o, rv, rs, rm, ri, ru, re, inr;
  logic [7:0]  rdat, other_pass_i = 0, verdict_o, mode, ev, op;
  logic [15:0] msk[8], code[8], fld;
  logic [7:0]  q[$];
  int          error_cnt = 0, check_count = 0, p;
  fofm_matcher uut (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .rx_valid_i(rv), .rx_data_i(rdat), .rx_sof_i(rs),
    .rx_mac_pl_i(rm), .rx_ipv4_pl_i(ri), .rx_udp_pl_i(ru), .rx_eof_i(re), .other_pass_i,
    .verdict_o, .verdict_valid_o);
  fofm_rx_model m (.mclk_i, .rx_valid_o(rv), .rx_data_o(rdat), .rx_sof_o(rs),
    .rx_mac_o(rm), .rx_ipv4_o(ri), .rx_udp_o(ru), .rx_eof_o(re));
  always #5 mclk_i = ~mclk_i;
  task automatic chk(string n, logic [31:0] x, logic [31:0] s);
    check_count++;
    if (s !== x) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(bit w, logic [11:0] a, logic [31:0] d);
    @(posedge mclk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge mclk_i);
    penable_i <= 1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    e = pslverr_o;
    {psel_i, penable_i} <= 2'h0;
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk_i)
    if (verdict_valid_o === 1'b1) chk("verdict", {24'h0, q.pop_front()}, {24'h0, verdict_o});
  initial begin
    #100000;
    error_cnt++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h0944e7c4));
    repeat (20) @(posedge mclk_i);
    rst_i <= 0;
    foreach (code[k]) begin
      apb(0, 12'h000 + 4 * k, 0);
      chk("reset value", 0, rd);
    end
    apb(0, 12'hffc, 32'h1);
    chk("unmapped", 32'h1, {rd[30:0], e});
    $display("register test done");
    for (int t = 0; t < 16; t++) begin
      op = $urandom;
      mode = $urandom;
      other_pass_i <= op;
      for (int i = 0; i < 40; i++) m.fb[i] = $urandom;
      p = (t % 4 == 0 ? 14 : t % 4 == 1 ? 20 : t % 4 == 2 ? 28 : 0) + (t < 4 ? 0 : t);
      inr = p + 1 < 40;
      fld = inr ? {m.fb[p], m.fb[p + 1]} : 16'($urandom);
      apb(1, `FOFM_ADDR_CTRL, t % 4);
      apb(1, `FOFM_ADDR_OFFSET, t < 4 ? 0 : t);
      apb(1, `FOFM_ADDR_MODE, {24'h0, mode});
      for (int i = 0; i < 8; i++) begin
        msk[i] = 16'($urandom) | 16'h0001;
        code[i] = fld ^ (i % 2 ? 16'h0001 : 16'($urandom) & ~msk[i]);
        apb(1, `FOFM_ADDR_FILT0 + 4 * i, {code[i], msk[i]});
        ev[i] = op[i] & (!mode[i] || inr && ((fld ^ code[i]) & msk[i]) == 0);
        cnt[i] += ev[i];
      end
      q.push_back(ev);
      m.play(40);
      $display("frame test %0d done", t);
    end
    for (int i = 0; i < 8; i++) begin
      apb(0, `FOFM_ADDR_CNT0 + 4 * i, 0);
      chk("count", cnt[i], rd);
      apb(0, `FOFM_ADDR_FILT0 + 4 * i, 0);
      chk("filter", {code[i], msk[i]}, rd);
    end
    $display("counter test done");
    complete_run;
  end
endmodule // testbench
